// *** include/drsr_pkg.sv ***
// Package for the drive read-only status register bank.
// Assumes a 100 MHz mclk and register reads by numeric assignment.
package drsr_pkg;

  // Register numeric assignments
  localparam logic [7:0] ADDR_ANALOG_ONE   = 8'h3a;
  localparam logic [7:0] ADDR_ANALOG_TWO   = 8'h3b;
  localparam logic [7:0] ADDR_ABS_POS      = 8'h3c;
  localparam logic [7:0] ADDR_CTRL_MODE    = 8'h3d;
  localparam logic [7:0] ADDR_VEL_STATE    = 8'h3e;
  localparam logic [7:0] ADDR_PT_STATE     = 8'h3f;
  localparam logic [7:0] ADDR_SEGMENT      = 8'h40;
  localparam logic [7:0] ADDR_MOTOR_CUR    = 8'h41;
  localparam logic [7:0] ADDR_CLAMP_PWR    = 8'h42;
  localparam logic [7:0] ADDR_STATUS_CODE  = 8'h43;
  localparam logic [7:0] ADDR_TEMPERATURE  = 8'h44;
  localparam logic [7:0] ADDR_BUS_VOLTAGE  = 8'h45;
  localparam logic [7:0] ADDR_ACT_VEL      = 8'h46;
  localparam logic [7:0] ADDR_TGT_VEL      = 8'h47;
  localparam logic [7:0] ADDR_POS_ERR      = 8'h48;
  localparam logic [7:0] ADDR_EXP_IO       = 8'h49;
  localparam logic [7:0] ADDR_PHASE_ERR    = 8'h4a;
  localparam logic [7:0] ADDR_PIN_STATUS   = 8'h39;

  // Pin layout variants
  localparam logic [1:0] LAYOUT_EIGHT_IN   = 2'h0;
  localparam logic [1:0] LAYOUT_PULSE_IN   = 2'h1;
  localparam logic [1:0] LAYOUT_FOUR_IN    = 2'h2;

  // Pin status field positions
  localparam int EIGHT_IN_LSB   = 0;
  localparam int EIGHT_OUT_LSB  = 8;
  localparam int EIGHT_IDX_BIT  = 12;
  localparam int PULSE_IDX_BIT  = 0;
  localparam int PULSE_STEP_BIT = 1;
  localparam int PULSE_DIR_BIT  = 2;
  localparam int PULSE_EN_BIT   = 3;
  localparam int PULSE_OUT_BIT  = 8;
  localparam int FOUR_IN_LSB    = 0;
  localparam int FOUR_OUT_LSB   = 8;
  localparam int FOUR_IDX_BIT   = 14;
  localparam int EXP_IN_LSB     = 0;
  localparam int EXP_OUT_LSB    = 8;
  localparam int EXP_ID_BIT     = 15;

  // Analog converter range
  localparam logic [15:0] ANALOG_MAX  = 16'h7ff8;
  localparam logic [15:0] ANALOG_ZERO = 16'h3fff;

  // End-of-move clean-up time
  localparam int PWM_CYCLE_NS   = 62000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PWM_CYCLES     = PWM_CYCLE_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 13;

  typedef enum logic [2:0] {
    VEL_WAITING, VEL_RUNNING, VEL_FAST_STOP, VEL_CTRL_STOP, VEL_ENDING
  } drsr_vel_e;

  typedef enum logic [3:0] {
    PT_WAITING, PT_BRAKE_WAIT, PT_CALC, PT_ACCEL, PT_CHANGE_VEL,
    PT_AT_VEL, PT_DECEL, PT_FAST_DECEL, PT_POSITIONING
  } drsr_pt_e;

  // Halt command encodings
  localparam logic [2:0] HALT_NONE        = 3'h0;
  localparam logic [2:0] HALT_PLAIN       = 3'h1;
  localparam logic [2:0] HALT_FLUSH       = 3'h2;
  localparam logic [2:0] HALT_JOG         = 3'h3;
  localparam logic [2:0] HALT_DECEL       = 3'h4;
  localparam logic [2:0] HALT_DECEL_FLUSH = 3'h5;

endpackage : drsr_pkg

// *** rtl/drsr_bank.sv ***
// Read-only status register bank of a motion drive, with move sequencers.
// Assumes register queries arrive already decoded from the serial link,
// and all inputs are synchronous to mclk.
// How it works
// - Eight-input layout: inputs bits 0-7, outputs 8-11, index bit 12.
// - Input and index bits read 1 when open, 0 when closed.
// - Output bits read 1 when closed, 0 when open.
// - Pulse layout: index 0, step 1, direction 2, enable 3, output 8.
// - Four-input layout: inputs 0-3, outputs 8-9, index bit 14.
// - Analog registers hold raw counts 0 to 32760, 16383 is zero volts.
// - Velocity state: waiting, running, fast stop, controlled stop, ending.
// - Ending or positioning state lasts exactly one 62 us PWM cycle.
// - Plain halts give fast stop; jog or decel halts give controlled stop.
// - Point state codes 0 to 8, waiting through positioning.
// - Point sequencer waits in state 1 until the brake releases.
// - Point state only meaningful during feed moves.
// - Stepper target velocity updates only with stall detection or prevention.
// - Expanded word: inputs 0-7, outputs 8-11, open reads 1, 12-14 zero.
// - Expanded word bit 15 is 1 when the expansion board is fitted.
// - Short registers 16 bits, long registers 32 bits, signed.

`timescale 1ns/1ps

module drsr_bank (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Configuration
  input  wire logic [1:0]  pin_layout,
  input  wire logic        is_stepper,
  input  wire logic        stall_guard_on,
  input  wire logic        expansion_fitted,
  // Pin levels, 1 means closed
  input  wire logic [7:0]  input_closed,
  input  wire logic [3:0]  output_closed,
  input  wire logic        index_closed,
  input  wire logic        step_closed,
  input  wire logic        dir_closed,
  input  wire logic        enable_closed,
  input  wire logic [7:0]  top_input_closed,
  input  wire logic [3:0]  top_output_closed,
  // Measured values
  input  wire logic [15:0] analog_one_raw,
  input  wire logic [15:0] analog_two_raw,
  input  wire logic [31:0] abs_position,
  input  wire logic [15:0] ctrl_mode,
  input  wire logic [15:0] segment_num,
  input  wire logic [15:0] motor_current,
  input  wire logic [15:0] clamp_power,
  input  wire logic [15:0] status_code,
  input  wire logic [15:0] temperature,
  input  wire logic [15:0] bus_volts,
  input  wire logic [15:0] act_velocity,
  input  wire logic [15:0] tgt_velocity,
  input  wire logic [31:0] pos_error,
  input  wire logic [15:0] phase_err,
  // Velocity move events
  input  wire logic        jog_start,
  input  wire logic [2:0]  halt_kind,
  input  wire logic        vel_stopped,
  // Point move events
  input  wire logic        feed_start,
  input  wire logic        brake_released,
  input  wire logic        calc_done,
  input  wire logic        accel_done,
  input  wire logic        speed_change,
  input  wire logic        decel_begin,
  input  wire logic        pt_stopped,
  // Register query port
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_addr,
  input  wire logic        wr_req,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  output logic             rd_err,
  output logic [3:0]       pt_state_out,
  output logic [2:0]       vel_state_out
);

  // Clamp raw converter count
  function automatic logic [15:0] clamp_adc(input logic [15:0] v);
    clamp_adc = (v > drsr_pkg::ANALOG_MAX) ? drsr_pkg::ANALOG_MAX : v;
  endfunction : clamp_adc

  // Sign-extend a short register
  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction : sx16

  // Halt commands that stop at full rate
  function automatic logic fast_halt(input logic [2:0] k);
    fast_halt = (k == drsr_pkg::HALT_PLAIN) || (k == drsr_pkg::HALT_FLUSH);
  endfunction : fast_halt

  // Halt commands that ramp down
  function automatic logic ramp_halt(input logic [2:0] k);
    ramp_halt = (k == drsr_pkg::HALT_JOG) || (k == drsr_pkg::HALT_DECEL)
                || (k == drsr_pkg::HALT_DECEL_FLUSH);
  endfunction : ramp_halt

  drsr_pkg::drsr_vel_e vel_reg, vel_next;
  drsr_pkg::drsr_pt_e  pt_reg,  pt_next;
  logic [drsr_pkg::CNT_W-1:0] vcnt_reg, vcnt_next, pcnt_reg, pcnt_next;
  logic [15:0] tgt_vel_reg, tgt_vel_next;
  logic [15:0] pin_word, exp_word;
  logic        rd_valid_reg, rd_valid_next, rd_err_reg, rd_err_next;
  logic [31:0] rd_data_reg, rd_data_next;

  localparam logic [drsr_pkg::CNT_W-1:0] END_CNT =
    drsr_pkg::CNT_W'(drsr_pkg::PWM_CYCLES - 1);

  // Pin status word packing
  always_comb
  begin
    pin_word = 16'h0000;
    case (pin_layout)
      drsr_pkg::LAYOUT_PULSE_IN:
      begin
        pin_word[drsr_pkg::PULSE_IDX_BIT]  = ~index_closed;
        pin_word[drsr_pkg::PULSE_STEP_BIT] = ~step_closed;
        pin_word[drsr_pkg::PULSE_DIR_BIT]  = ~dir_closed;
        pin_word[drsr_pkg::PULSE_EN_BIT]   = ~enable_closed;
        pin_word[drsr_pkg::PULSE_OUT_BIT]  = output_closed[0];
      end
      drsr_pkg::LAYOUT_FOUR_IN:
      begin
        pin_word[drsr_pkg::FOUR_IN_LSB +: 4]  = ~input_closed[3:0];
        pin_word[drsr_pkg::FOUR_OUT_LSB +: 2] = output_closed[1:0];
        pin_word[drsr_pkg::FOUR_IDX_BIT]      = ~index_closed;
      end
      default:
      begin
        pin_word[drsr_pkg::EIGHT_IN_LSB +: 8]  = ~input_closed;
        pin_word[drsr_pkg::EIGHT_OUT_LSB +: 4] = output_closed;
        pin_word[drsr_pkg::EIGHT_IDX_BIT]      = ~index_closed;
      end
    endcase
  end

  // Expanded I/O word
  always_comb
  begin
    exp_word = 16'h0000;
    exp_word[drsr_pkg::EXP_IN_LSB +: 8]  = ~top_input_closed;
    exp_word[drsr_pkg::EXP_OUT_LSB +: 4] = ~top_output_closed;
    exp_word[drsr_pkg::EXP_ID_BIT]       = expansion_fitted;
  end

  // Velocity sequencer
  always_comb
  begin
    vel_next  = vel_reg;
    vcnt_next = vcnt_reg;
    case (vel_reg)
      drsr_pkg::VEL_WAITING:
        if (jog_start)
          vel_next = drsr_pkg::VEL_RUNNING;
      drsr_pkg::VEL_RUNNING:
        if (fast_halt(halt_kind))
          vel_next = drsr_pkg::VEL_FAST_STOP;
        else if (ramp_halt(halt_kind))
          vel_next = drsr_pkg::VEL_CTRL_STOP;
      drsr_pkg::VEL_FAST_STOP, drsr_pkg::VEL_CTRL_STOP:
        if (vel_stopped)
        begin
          vel_next  = drsr_pkg::VEL_ENDING;
          vcnt_next = '0;
        end
      drsr_pkg::VEL_ENDING:
      begin
        vcnt_next = vcnt_reg + 1'b1;
        if (vcnt_reg == END_CNT)
          vel_next = drsr_pkg::VEL_WAITING;
      end
      default:
        vel_next = drsr_pkg::VEL_WAITING;
    endcase
  end

  // Point-to-point sequencer
  always_comb
  begin
    pt_next   = pt_reg;
    pcnt_next = pcnt_reg;
    case (pt_reg)
      drsr_pkg::PT_WAITING:
        if (feed_start)
          pt_next = drsr_pkg::PT_BRAKE_WAIT;
      drsr_pkg::PT_BRAKE_WAIT:
        if (brake_released)
          pt_next = drsr_pkg::PT_CALC;
      drsr_pkg::PT_CALC:
        if (calc_done)
          pt_next = drsr_pkg::PT_ACCEL;
      drsr_pkg::PT_ACCEL, drsr_pkg::PT_CHANGE_VEL, drsr_pkg::PT_AT_VEL:
        if (fast_halt(halt_kind))
          pt_next = drsr_pkg::PT_FAST_DECEL;
        else if (decel_begin)
          pt_next = drsr_pkg::PT_DECEL;
        else if (speed_change)
          pt_next = drsr_pkg::PT_CHANGE_VEL;
        else if (accel_done)
          pt_next = drsr_pkg::PT_AT_VEL;
      drsr_pkg::PT_DECEL, drsr_pkg::PT_FAST_DECEL:
        if (pt_stopped)
        begin
          pt_next   = drsr_pkg::PT_POSITIONING;
          pcnt_next = '0;
        end
      drsr_pkg::PT_POSITIONING:
      begin
        pcnt_next = pcnt_reg + 1'b1;
        if (pcnt_reg == END_CNT)
          pt_next = drsr_pkg::PT_WAITING;
      end
      default:
        pt_next = drsr_pkg::PT_WAITING;
    endcase
  end

  // Target velocity capture
  always_comb
  begin
    tgt_vel_next = tgt_vel_reg;
    if (!is_stepper || stall_guard_on)
      tgt_vel_next = tgt_velocity;
  end

  // Query answer, reads have no side effect
  always_comb
  begin
    rd_valid_next = rd_req;
    rd_err_next   = 1'b0;
    rd_data_next  = rd_data_reg;
    if (rd_req)
    begin
      case (rd_addr)
        drsr_pkg::ADDR_ANALOG_ONE:  rd_data_next = sx16(clamp_adc(analog_one_raw));
        drsr_pkg::ADDR_ANALOG_TWO:  rd_data_next = sx16(clamp_adc(analog_two_raw));
        drsr_pkg::ADDR_ABS_POS:     rd_data_next = abs_position;
        drsr_pkg::ADDR_CTRL_MODE:   rd_data_next = sx16(ctrl_mode);
        drsr_pkg::ADDR_VEL_STATE:   rd_data_next = {29'h0, vel_reg};
        drsr_pkg::ADDR_PT_STATE:    rd_data_next = {28'h0, pt_reg};
        drsr_pkg::ADDR_SEGMENT:     rd_data_next = sx16(segment_num);
        drsr_pkg::ADDR_MOTOR_CUR:   rd_data_next = sx16(motor_current);
        drsr_pkg::ADDR_CLAMP_PWR:   rd_data_next = sx16(clamp_power);
        drsr_pkg::ADDR_STATUS_CODE: rd_data_next = sx16(status_code);
        drsr_pkg::ADDR_TEMPERATURE: rd_data_next = sx16(temperature);
        drsr_pkg::ADDR_BUS_VOLTAGE: rd_data_next = sx16(bus_volts);
        drsr_pkg::ADDR_ACT_VEL:     rd_data_next = sx16(act_velocity);
        drsr_pkg::ADDR_TGT_VEL:     rd_data_next = sx16(tgt_vel_reg);
        drsr_pkg::ADDR_POS_ERR:     rd_data_next = pos_error;
        drsr_pkg::ADDR_EXP_IO:      rd_data_next = sx16(exp_word);
        drsr_pkg::ADDR_PHASE_ERR:   rd_data_next = sx16(phase_err);
        drsr_pkg::ADDR_PIN_STATUS:  rd_data_next = sx16(pin_word);
        default:
        begin
          rd_data_next = 32'h0000_0000;
          rd_err_next  = 1'b1;
        end
      endcase
    end
    else if (wr_req)
    begin
      rd_valid_next = 1'b0;
    end
  end

  // Velocity sequencer state
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vel_reg  <= drsr_pkg::VEL_WAITING;
      vcnt_reg <= '0;
    end
    else if (clk_en)
    begin
      vel_reg  <= vel_next;
      vcnt_reg <= vcnt_next;
    end
  end

  // Point sequencer state
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pt_reg   <= drsr_pkg::PT_WAITING;
      pcnt_reg <= '0;
    end
    else if (clk_en)
    begin
      pt_reg   <= pt_next;
      pcnt_reg <= pcnt_next;
    end
  end

  // Held target velocity
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tgt_vel_reg <= 16'h0000;
    end
    else if (clk_en)
    begin
      tgt_vel_reg <= tgt_vel_next;
    end
  end

  // Query answer registers
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_valid_reg <= 1'b0;
      rd_err_reg   <= 1'b0;
      rd_data_reg  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      rd_valid_reg <= rd_valid_next;
      rd_err_reg   <= rd_err_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  assign rd_valid      = rd_valid_reg;
  assign rd_err        = rd_err_reg;
  assign rd_data       = rd_data_reg;
  assign pt_state_out  = pt_reg;
  assign vel_state_out = vel_reg;

endmodule : drsr_bank

// *** verification/drsr_bank_monitor.sv ***
// Port checker for the read-only status bank.
// Assumes clk_en gates every state change.
`timescale 1ns/1ps
module drsr_bank_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // Inputs watched
  input wire logic        expansion_fitted,
  input wire logic        jog_start,
  input wire logic [2:0]  halt_kind,
  input wire logic        feed_start,
  input wire logic        brake_released,
  input wire logic        rd_req,
  input wire logic [7:0]  rd_addr,
  // Outputs watched
  input wire logic        rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic        rd_err,
  input wire logic [3:0]  pt_state_out,
  input wire logic [2:0]  vel_state_out
);
  logic [12:0] end_cnt_reg;
  logic [12:0] end_cnt_next;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Cycles spent in the ending state
  always_comb end_cnt_next = (vel_state_out == 3'h4) ? end_cnt_reg + 13'h1 : 13'h0;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst) end_cnt_reg <= 13'h0;
    else if (clk_en) end_cnt_reg <= end_cnt_next;
  end

  rd_answer_a: assert property (rd_req && clk_en |=> rd_valid)
    else $error("read not answered");
  rd_quiet_a: assert property (!rd_req && clk_en |=> !rd_valid)
    else $error("answer without read");
  err_zero_a: assert property (rd_err |-> rd_valid && rd_data == 32'h0)
    else $error("error answer malformed");
  exp_id_a: assert property (rd_req && clk_en && rd_addr == 8'h49 |=>
    rd_data[15:12] == {$past(expansion_fitted), 3'h0}) else $error("board bit wrong");
  analog_max_a: assert property (rd_req && clk_en && rd_addr inside {8'h3a, 8'h3b}
    |=> rd_data <= 32'h7ff8) else $error("analog above range");
  jog_run_a: assert property (vel_state_out == 3'h0 && jog_start && clk_en
    |=> vel_state_out == 3'h1) else $error("jog not running");
  fast_stop_a: assert property (vel_state_out == 3'h1 && halt_kind inside {3'h1, 3'h2}
    && clk_en |=> vel_state_out == 3'h2) else $error("no fast stop");
  ctrl_stop_a: assert property (vel_state_out == 3'h1 && halt_kind inside {3'h3, 3'h4, 3'h5}
    && clk_en |=> vel_state_out == 3'h3) else $error("no controlled stop");
  end_len_a: assert property (vel_state_out == 3'h4 && end_cnt_reg < 13'd6199
    |=> vel_state_out == 3'h4) else $error("ending too short");
  end_max_a: assert property (vel_state_out == 3'h4 && end_cnt_reg == 13'd6199
    && clk_en |=> vel_state_out == 3'h0) else $error("ending too long");
  pt_start_a: assert property (pt_state_out == 4'h0 && feed_start && clk_en
    |=> pt_state_out == 4'h1) else $error("feed not started");
  brake_hold_a: assert property (pt_state_out == 4'h1 && !brake_released && clk_en
    |=> pt_state_out == 4'h1) else $error("left brake wait");
endmodule : drsr_bank_monitor

bind drsr_bank drsr_bank_monitor i_mon (.mclk, .sys_rst, .clk_en, .expansion_fitted,
  .jog_start, .halt_kind, .feed_start, .brake_released, .rd_req, .rd_addr, .rd_valid,
  .rd_data, .rd_err, .pt_state_out, .vel_state_out);

// *** verification/drsr_host.sv ***
// Host model issuing register load queries by numeric assignment.
// Assumes answers come one cycle after the query edge.
`timescale 1ns/1ps
module drsr_host (
  // Clock
  input wire logic        mclk,
  // Answer
  input wire logic        rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic        rd_err,
  // Query
  output logic            rd_req,
  output logic [7:0]      rd_addr,
  output logic            wr_req
);
  initial
  begin
    rd_req = 1'b0;
    rd_addr = 8'h0;
    wr_req = 1'b0;
  end

  task automatic rd(input logic [7:0] a, input logic w, output logic [31:0] d,
                    output logic e);
    @(posedge mclk);
    #1;
    rd_req = 1'b1;
    rd_addr = a;
    wr_req = w;
    @(posedge mclk);
    #1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    rd_addr = ~a;
    d = rd_data;
    e = (rd_valid === 1'b1) ? rd_err : 1'bx;
  endtask : rd
endmodule : drsr_host

// *** verification/tb_drsr_bank.sv ***
// Self-checking bench for the read-only status bank.
// Assumes the host model speaks the query port.
`timescale 1ns/1ps
module tb_drsr_bank;
  logic        mclk, sys_rst, is_stepper, stall_guard_on, expansion_fitted;
  logic        index_closed, step_closed, dir_closed, enable_closed, e;
  logic        jog_start, vel_stopped, brake_released, rd_req, wr_req, rd_valid, rd_err;
  logic        clk_en = 1'b1;
  logic [1:0]  pin_layout;
  logic [2:0]  halt_kind, vel_state_out;
  logic [3:0]  output_closed, top_output_closed, pt_state_out;
  logic [5:0]  pev;
  logic [7:0]  input_closed, top_input_closed, rd_addr;
  logic [15:0] analog_one_raw, analog_two_raw, ctrl_mode, segment_num, motor_current;
  logic [15:0] clamp_power, status_code, temperature, bus_volts, act_velocity;
  logic [15:0] tgt_velocity, phase_err, tgt_m;
  logic [31:0] abs_position, pos_error, d, rd_data;
  wire         feed_start, calc_done, accel_done, speed_change, decel_begin, pt_stopped;
  int          n_errors, comparisons;

  assign {feed_start, calc_done, accel_done, speed_change, decel_begin, pt_stopped} = pev;

  drsr_bank i_dut (.mclk, .sys_rst, .clk_en, .pin_layout, .is_stepper, .stall_guard_on,
    .expansion_fitted, .input_closed, .output_closed, .index_closed, .step_closed,
    .dir_closed, .enable_closed, .top_input_closed, .top_output_closed, .analog_one_raw,
    .analog_two_raw, .abs_position, .ctrl_mode, .segment_num, .motor_current, .clamp_power,
    .status_code, .temperature, .bus_volts, .act_velocity, .tgt_velocity, .pos_error,
    .phase_err, .jog_start, .halt_kind, .vel_stopped, .feed_start, .brake_released,
    .calc_done, .accel_done, .speed_change, .decel_begin, .pt_stopped, .rd_req, .rd_addr,
    .wr_req, .rd_valid, .rd_data, .rd_err, .pt_state_out, .vel_state_out);
  drsr_host i_host (.mclk, .rd_valid, .rd_data, .rd_err, .rd_req,
    .rd_addr, .wr_req);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin n_errors++; $display("[FAIL] %s expected %h seen %h", n, x, g); end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic rnd();
    {analog_one_raw, analog_two_raw, ctrl_mode, segment_num, motor_current, clamp_power,
     status_code, temperature, bus_volts, act_velocity, tgt_velocity, phase_err} =
      {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    {abs_position, pos_error} = {$urandom, $urandom};
    {input_closed, output_closed, index_closed, step_closed, dir_closed, enable_closed,
     top_input_closed, top_output_closed, is_stepper, stall_guard_on, expansion_fitted} =
      31'($urandom);
    if (!is_stepper || stall_guard_on) tgt_m = tgt_velocity;
  endtask : rnd

  function automatic logic [31:0] ex(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0;
    case (a)
      8'h39: case (pin_layout)
        2'h1: w = {7'h0, output_closed[0], 4'h0,
                   ~{enable_closed, dir_closed, step_closed, index_closed}};
        2'h2: w = {1'b0, ~index_closed, 4'h0, output_closed[1:0], 4'h0, ~input_closed[3:0]};
        default: w = {3'h0, ~index_closed, output_closed, ~input_closed};
      endcase
      8'h3a: w = (analog_one_raw > 16'h7ff8) ? 16'h7ff8 : analog_one_raw;
      8'h3b: w = (analog_two_raw > 16'h7ff8) ? 16'h7ff8 : analog_two_raw;
      8'h3c: return abs_position;
      8'h3d: w = ctrl_mode;
      8'h40: w = segment_num;
      8'h41: w = motor_current;
      8'h42: w = clamp_power;
      8'h43: w = status_code;
      8'h44: w = temperature;
      8'h45: w = bus_volts;
      8'h46: w = act_velocity;
      8'h47: w = tgt_m;
      8'h48: return pos_error;
      8'h49: w = {expansion_fitted, 3'h0, ~top_output_closed, ~top_input_closed};
      8'h4a: w = phase_err;
      default: w = 16'h0;
    endcase
    return {{16{w[15]}}, w};
  endfunction : ex

  task automatic pt(input int b, input int x);
    pev[b] = 1'b1;
    step(1);
    pev = 6'h0;
    chk("pt", x, pt_state_out);
  endtask : pt

  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  initial
  begin
    #800000;
    n_errors++;
    results();
  end

  initial
  begin
    void'($urandom(32'h949fcd96));
    {sys_rst, pev, jog_start, halt_kind, vel_stopped, brake_released, tgt_m} = {1'b1, 28'h0};
    pin_layout = 2'h0;
    rnd();
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'b0;
    for (int L = 0; L < 4; L++)
    begin
      pin_layout = L[1:0];
      rnd();
      for (int a = 8'h39; a <= 8'h4a; a++)
        if (a != 8'h3f)
        begin
          i_host.rd(a[7:0], 1'($urandom), d, e);
          chk("reg", ex(a[7:0]), d);
          chk("err", 0, {31'h0, e});
        end
    end
    is_stepper = 1'b1;
    stall_guard_on = 1'b0;
    tgt_velocity = ~tgt_m;
    i_host.rd(8'h47, 1'b0, d, e);
    chk("tgt", {{16{tgt_m[15]}}, tgt_m}, d);
    i_host.rd(8'h49, 1'b0, d, e);
    chk("exp_masked", ex(8'h49) & 32'h0000_0fff, d & 32'h0000_0fff);
    i_host.rd(8'h00, 1'b1, d, e);
    chk("unmapped", 0, d);
    chk("unmapped_err", 1, {31'h0, e});
    for (int k = 1; k < 6; k++)
    begin
      jog_start = 1'b1;
      step(1);
      jog_start = 1'b0;
      chk("vel", 1, vel_state_out);
      halt_kind = k[2:0];
      step(1);
      halt_kind = 3'h0;
      i_host.rd(8'h3e, 1'b0, d, e);
      chk("vreg", (k < 3) ? 2 : 3, d);
      vel_stopped = 1'b1;
      step(1);
      vel_stopped = 1'b0;
      step(6199);
      chk("vel", 4, vel_state_out);
      step(1);
      chk("vel", 0, vel_state_out);
    end
    pt(5, 1);
    step(3);
    i_host.rd(8'h3f, 1'b0, d, e);
    chk("preg", 1, d);
    brake_released = 1'b1;
    step(1);
    chk("pt", 2, pt_state_out);
    pt(4, 3);
    pt(2, 4);
    pt(3, 5);
    pt(1, 6);
    pt(0, 8);
    step(6199);
    chk("pt", 8, pt_state_out);
    step(1);
    chk("pt", 0, pt_state_out);
    pt(5, 1);
    pt(4, 2);
    pt(4, 3);
    halt_kind = 3'h1;
    step(1);
    halt_kind = 3'h0;
    chk("pt", 7, pt_state_out);
    pt(0, 8);
    step(6200);
    chk("pt", 0, pt_state_out);
    results();
  end
endmodule : tb_drsr_bank
